// [rtl/aid_core.sv]
`timescale 1ns/100ps
// alu instruction decoder subset: fetch, operand, timed execute, write back
module aid_core (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // program memory
    output logic mem_req,
    output logic [15:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [7:0] mem_data,
    // register file view
    input wire logic [7:0] reg_b,
    input wire logic [7:0] reg_c,
    input wire logic [7:0] reg_d,
    input wire logic [7:0] reg_e,
    input wire logic [15:0] sp,
    input wire logic [15:0] pc,
    // results
    output aid_pkg::aid_arch_t arch,
    output logic done,
    output logic [3:0] done_states,
    output logic [7:0] done_opcode
);
    aid_pkg::aid_state_t state, next_state;
    aid_pkg::aid_dec_t dec, cur, next_cur;
    aid_pkg::aid_arch_t next_arch;
    logic [7:0] opcode, next_opcode, operand, next_operand;
    logic [3:0] tcount, next_tcount;
    logic next_done, next_mem_req;
    logic [15:0] next_mem_addr;
    logic [7:0] src_val, diff, xres;
    logic [8:0] sub9;
    logic [16:0] sum17;
    logic [3:0] used;

    aid_opdec aid_opdec_inst (
        .opcode(mem_data),
        .dec(dec)
    );

    always_comb begin
        case (cur.sel)
            aid_pkg::SEL_B: src_val = reg_b;
            aid_pkg::SEL_C: src_val = reg_c;
            aid_pkg::SEL_D: src_val = reg_d;
            aid_pkg::SEL_E: src_val = reg_e;
            aid_pkg::SEL_H: src_val = arch.hl[15:8];
            aid_pkg::SEL_L: src_val = arch.hl[7:0];
            aid_pkg::SEL_MEM: src_val = operand;
            default: src_val = arch.acc;
        endcase
        if (cur.src == aid_pkg::AID_SRC_IMM) begin
            src_val = operand;
        end
    end

    always_comb begin
        sub9 = {1'b0, arch.acc} - {1'b0, src_val};
        diff = sub9[7:0];
        xres = arch.acc ^ src_val;
        sum17 = {1'b0, arch.hl} + {1'b0, sp};
    end

    always_comb begin
        next_state = state;
        next_cur = cur;
        next_arch = arch;
        next_opcode = opcode;
        next_operand = operand;
        next_tcount = tcount;
        next_done = 1'b0;
        next_mem_req = 1'b0;
        next_mem_addr = mem_addr;
        used = 4'h0;
        case (state)
            aid_pkg::AID_FETCH: begin
                next_mem_req = 1'b1;
                next_mem_addr = pc;
                next_tcount = tcount + 4'h1;
                if (mem_req && mem_ack) begin
                    next_mem_req = 1'b0;
                    next_opcode = mem_data;
                    next_cur = dec;
                    next_tcount = 4'h1;
                    if (dec.src == aid_pkg::AID_SRC_MEM
                            || dec.src == aid_pkg::AID_SRC_IMM) begin
                        next_state = aid_pkg::AID_OPER;
                    end else begin
                        next_state = aid_pkg::AID_WAIT;
                    end
                end else begin
                    next_tcount = 4'h0;
                end
            end
            aid_pkg::AID_OPER: begin
                next_mem_req = 1'b1;
                next_mem_addr = (cur.src == aid_pkg::AID_SRC_MEM) ? arch.hl
                                                                 : pc + 16'h0001;
                next_tcount = tcount + 4'h1;
                if (mem_req && mem_ack) begin
                    next_mem_req = 1'b0;
                    next_operand = mem_data;
                    next_state = aid_pkg::AID_WAIT;
                end
            end
            aid_pkg::AID_WAIT: begin
                // stretch to the documented state count; the last state executes
                next_tcount = tcount + 4'h1;
                used = tcount + 4'h1;
                if (used >= cur.states - 4'h1) begin
                    next_state = aid_pkg::AID_EXEC;
                end
            end
            aid_pkg::AID_EXEC: begin
                next_state = aid_pkg::AID_DONE;
                case (cur.op)
                    aid_pkg::AID_OP_CMP: begin
                        next_arch.flags[aid_pkg::FLAG_CY] = sub9[8];
                        next_arch.flags[aid_pkg::FLAG_Z] = (diff == 8'h00);
                        next_arch.flags[aid_pkg::FLAG_S] = diff[7];
                        next_arch.flags[aid_pkg::FLAG_P] = ~^diff;
                        next_arch.flags[aid_pkg::FLAG_AC] = arch.acc[3:0] < src_val[3:0];
                    end
                    aid_pkg::AID_OP_XOR: begin
                        next_arch.acc = xres;
                        next_arch.flags[aid_pkg::FLAG_CY] = 1'b0;
                        next_arch.flags[aid_pkg::FLAG_AC] = 1'b0;
                        next_arch.flags[aid_pkg::FLAG_Z] = (xres == 8'h00);
                        next_arch.flags[aid_pkg::FLAG_S] = xres[7];
                        next_arch.flags[aid_pkg::FLAG_P] = ~^xres;
                    end
                    aid_pkg::AID_OP_RAL: begin
                        next_arch.acc = {arch.acc[6:0], arch.flags[aid_pkg::FLAG_CY]};
                        next_arch.flags[aid_pkg::FLAG_CY] = arch.acc[7];
                    end
                    aid_pkg::AID_OP_RAR: begin
                        next_arch.acc = {arch.flags[aid_pkg::FLAG_CY], arch.acc[7:1]};
                        next_arch.flags[aid_pkg::FLAG_CY] = arch.acc[0];
                    end
                    aid_pkg::AID_OP_DAD: begin
                        next_arch.hl = sum17[15:0];
                        next_arch.flags[aid_pkg::FLAG_CY] = sum17[16];
                    end
                    default: begin
                        next_arch = arch;
                    end
                endcase
            end
            aid_pkg::AID_DONE: begin
                // done marks the end of the final state
                next_done = 1'b1;
                next_state = aid_pkg::AID_FETCH;
                next_tcount = 4'h0;
            end
            default: begin
                next_state = aid_pkg::AID_FETCH;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= aid_pkg::AID_FETCH;
            cur <= '0;
            arch <= '{acc: 8'h00, flags: aid_pkg::FLAGS_RST, hl: 16'h0000};
            opcode <= 8'h00;
            operand <= 8'h00;
            tcount <= 4'h0;
            done <= 1'b0;
            mem_req <= 1'b0;
            mem_addr <= 16'h0000;
            done_states <= 4'h0;
            done_opcode <= 8'h00;
        end else begin
            state <= next_state;
            cur <= next_cur;
            arch <= next_arch;
            opcode <= next_opcode;
            operand <= next_operand;
            tcount <= next_tcount;
            done <= next_done;
            mem_req <= next_mem_req;
            mem_addr <= next_mem_addr;
            done_states <= next_done ? cur.states : done_states;
            done_opcode <= next_done ? opcode : done_opcode;
        end
    end

    a_cmp_keeps_acc: assert property (@(posedge core_clk) disable iff (rst)
        (state == aid_pkg::AID_EXEC && cur.op == aid_pkg::AID_OP_CMP)
        |=> $stable(arch.acc))
        else $error("compare changed accumulator");
    a_cmp_reg_states: assert property (@(posedge core_clk) disable iff (rst)
        (done && done_opcode[7:3] == aid_pkg::OPC_CMP_HI
         && done_opcode[2:0] != aid_pkg::SEL_MEM) |-> done_states == aid_pkg::ST_REG)
        else $error("register compare not 4 states");
    a_cmp_mem_states: assert property (@(posedge core_clk) disable iff (rst)
        (done && done_opcode == {aid_pkg::OPC_CMP_HI, aid_pkg::SEL_MEM})
        |-> done_states == aid_pkg::ST_MEM)
        else $error("memory compare not 7 states");
    a_xri_result: assert property (@(posedge core_clk) disable iff (rst)
        (state == aid_pkg::AID_EXEC && cur.op == aid_pkg::AID_OP_XOR
         && cur.src == aid_pkg::AID_SRC_IMM)
        |=> arch.acc == ($past(arch.acc) ^ $past(operand)))
        else $error("xor immediate result wrong");
    a_xra_result: assert property (@(posedge core_clk) disable iff (rst)
        (state == aid_pkg::AID_EXEC && cur.op == aid_pkg::AID_OP_XOR)
        |=> arch.acc == ($past(arch.acc) ^ $past(src_val))
            && !arch.flags[aid_pkg::FLAG_CY])
        else $error("xor register result wrong");
    a_ral_loop: assert property (@(posedge core_clk) disable iff (rst)
        (state == aid_pkg::AID_EXEC && cur.op == aid_pkg::AID_OP_RAL)
        |=> {arch.flags[0], arch.acc}
            == {$past(arch.acc), $past(arch.flags[0])})
        else $error("left rotate through carry wrong");
    a_rar_loop: assert property (@(posedge core_clk) disable iff (rst)
        (state == aid_pkg::AID_EXEC && cur.op == aid_pkg::AID_OP_RAR)
        |=> {arch.acc, arch.flags[0]}
            == {$past(arch.flags[0]), $past(arch.acc)})
        else $error("right rotate through carry wrong");
    a_dad_states: assert property (@(posedge core_clk) disable iff (rst)
        (state == aid_pkg::AID_FETCH && mem_req && mem_ack
         && mem_data == aid_pkg::OPC_DAD_SP) |=> ##10 done)
        else $error("pair add not 10 states");
    a_mem_sel_hl: assert property (@(posedge core_clk) disable iff (rst)
        (state == aid_pkg::AID_OPER && cur.src == aid_pkg::AID_SRC_MEM
         && $past(state) == aid_pkg::AID_OPER) |-> mem_addr == arch.hl)
        else $error("memory operand not from hl");
endmodule

// [rtl/aid_opdec.sv]
`timescale 1ns/100ps
// opcode classifier: operation, operand source, selector and state count
module aid_opdec (
    // opcode in
    input wire logic [7:0] opcode,
    // decode out
    output aid_pkg::aid_dec_t dec
);
    always_comb begin
        dec.op = aid_pkg::AID_OP_NONE;
        dec.src = aid_pkg::AID_SRC_NONE;
        dec.sel = opcode[2:0];
        dec.states = aid_pkg::ST_NONE;
        if (opcode[7:3] == aid_pkg::OPC_CMP_HI) begin
            dec.op = aid_pkg::AID_OP_CMP;
            if (opcode[2:0] == aid_pkg::SEL_MEM) begin
                dec.src = aid_pkg::AID_SRC_MEM;
                dec.states = aid_pkg::ST_MEM;
            end else begin
                dec.src = aid_pkg::AID_SRC_REG;
                dec.states = aid_pkg::ST_REG;
            end
        end else if (opcode[7:3] == aid_pkg::OPC_XRA_HI) begin
            dec.op = aid_pkg::AID_OP_XOR;
            if (opcode[2:0] == aid_pkg::SEL_MEM) begin
                dec.src = aid_pkg::AID_SRC_MEM;
                dec.states = aid_pkg::ST_MEM;
            end else begin
                dec.src = aid_pkg::AID_SRC_REG;
                dec.states = aid_pkg::ST_REG;
            end
        end else if (opcode == aid_pkg::OPC_XRI) begin
            dec.op = aid_pkg::AID_OP_XOR;
            dec.src = aid_pkg::AID_SRC_IMM;
            dec.states = aid_pkg::ST_IMM;
        end else if (opcode == aid_pkg::OPC_RAL) begin
            dec.op = aid_pkg::AID_OP_RAL;
            dec.states = aid_pkg::ST_ROT;
        end else if (opcode == aid_pkg::OPC_RAR) begin
            dec.op = aid_pkg::AID_OP_RAR;
            dec.states = aid_pkg::ST_ROT;
        end else if (opcode == aid_pkg::OPC_DAD_SP) begin
            dec.op = aid_pkg::AID_OP_DAD;
            dec.states = aid_pkg::ST_PAIR;
        end
    end
endmodule

// [shared/aid_pkg.sv]
// package: opcodes, selector codes, state counts and carried types for the alu decoder
package aid_pkg;
    // register selector codes
    localparam logic [2:0] SEL_B = 3'h0;
    localparam logic [2:0] SEL_C = 3'h1;
    localparam logic [2:0] SEL_D = 3'h2;
    localparam logic [2:0] SEL_E = 3'h3;
    localparam logic [2:0] SEL_H = 3'h4;
    localparam logic [2:0] SEL_L = 3'h5;
    localparam logic [2:0] SEL_MEM = 3'h6;
    localparam logic [2:0] SEL_A = 3'h7;
    // opcode patterns
    localparam logic [4:0] OPC_CMP_HI = 5'h17;
    localparam logic [4:0] OPC_XRA_HI = 5'h15;
    localparam logic [7:0] OPC_XRI = 8'hEE;
    localparam logic [7:0] OPC_RAL = 8'h17;
    localparam logic [7:0] OPC_RAR = 8'h1F;
    localparam logic [7:0] OPC_DAD_SP = 8'h39;
    // clock states per instruction
    localparam logic [3:0] ST_REG = 4'h4;
    localparam logic [3:0] ST_MEM = 4'h7;
    localparam logic [3:0] ST_IMM = 4'h7;
    localparam logic [3:0] ST_ROT = 4'h4;
    localparam logic [3:0] ST_PAIR = 4'hA;
    localparam logic [3:0] ST_NONE = 4'h4;
    // flag bit positions
    localparam int FLAG_CY = 0;
    localparam int FLAG_P = 2;
    localparam int FLAG_AC = 4;
    localparam int FLAG_Z = 6;
    localparam int FLAG_S = 7;
    localparam logic [7:0] FLAGS_RST = 8'h02;

    typedef enum logic [4:0] {
        AID_FETCH = 5'b00001,
        AID_OPER = 5'b00010,
        AID_WAIT = 5'b00100,
        AID_EXEC = 5'b01000,
        AID_DONE = 5'b10000
    } aid_state_t;

    typedef enum logic [2:0] {
        AID_OP_NONE = 3'h0,
        AID_OP_CMP = 3'h1,
        AID_OP_XOR = 3'h2,
        AID_OP_RAL = 3'h3,
        AID_OP_RAR = 3'h4,
        AID_OP_DAD = 3'h5
    } aid_op_t;

    typedef enum logic [1:0] {
        AID_SRC_REG = 2'h0,
        AID_SRC_MEM = 2'h1,
        AID_SRC_IMM = 2'h2,
        AID_SRC_NONE = 2'h3
    } aid_src_t;

    typedef struct packed {
        aid_op_t op;
        aid_src_t src;
        logic [2:0] sel;
        logic [3:0] states;
    } aid_dec_t;

    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] flags;
        logic [15:0] hl;
    } aid_arch_t;
endpackage

// [tb/aid_core_tb.sv]
`timescale 1ns/100ps
// self-checking bench for the alu decoder subset
module aid_core_tb;
    logic core_clk;
    logic rst;
    logic mem_req;
    logic [15:0] mem_addr;
    logic mem_ack;
    logic [7:0] mem_data;
    logic [7:0] reg_b;
    logic [7:0] reg_c;
    logic [7:0] reg_d;
    logic [7:0] reg_e;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [3:0] lag;
    aid_pkg::aid_arch_t arch;
    logic done;
    logic [3:0] done_states;
    logic [7:0] done_opcode;
    int n_errors;
    int n_checks;
    int cycles = 0;
    logic [7:0] acc_m;
    logic cy_m;
    logic [15:0] hl_m;
    logic [15:0] pc_v;

    aid_core aid_core_inst (.core_clk(core_clk), .rst(rst), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_data(mem_data), .reg_b(reg_b),
        .reg_c(reg_c), .reg_d(reg_d), .reg_e(reg_e), .sp(sp), .pc(pc), .arch(arch),
        .done(done), .done_states(done_states), .done_opcode(done_opcode));
    aid_prog_mem aid_prog_mem_inst (.core_clk(core_clk), .rst(rst), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_data(mem_data), .lag(lag));

    initial core_clk = 1'b0;
    always #10 core_clk = ~core_clk;

    // hang guard: the whole sequence needs under two hundred cycles
    always @(posedge core_clk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            n_errors = n_errors + 1;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    function automatic logic [7:0] src_of(input logic [2:0] sel);
        case (sel)
            3'h0: return reg_b;
            3'h1: return reg_c;
            3'h2: return reg_d;
            3'h3: return reg_e;
            3'h4: return hl_m[15:8];
            3'h5: return hl_m[7:0];
            3'h6: return aid_prog_mem_inst.store[hl_m];
            default: return acc_m;
        endcase
    endfunction

    function automatic logic [7:0] cmp_flags(input logic [7:0] a, input logic [7:0] s);
        logic [7:0] r;
        r = a - s;
        return {r[7], a == s, 1'b0, a[3:0] < s[3:0], 1'b0, ~^r, 1'b0, a < s};
    endfunction

    // one instruction at pc_v; the timing is checked only with a prompt memory
    task automatic run_op(input logic [7:0] op, input logic [7:0] imm, input logic [3:0] st);
        int n;
        aid_prog_mem_inst.store[pc_v] = op;
        aid_prog_mem_inst.store[pc_v + 16'h0001] = imm;
        pc = pc_v;
        n = 0;
        while (!(mem_req === 1'b1 && mem_ack === 1'b1) && n < 40) begin
            @(negedge core_clk);
            n = n + 1;
        end
        @(negedge core_clk);
        n = 0;
        while (done !== 1'b1 && n < 60) begin
            @(negedge core_clk);
            n = n + 1;
        end
        // a hang shows up here instead of only as stale result fields
        chk({15'h0000, done}, 16'h0001, "done pulse");
        if (lag == 4'h0) begin
            chk(n[15:0], {12'h000, st}, "cycles to done");
        end
        chk({12'h000, done_states}, {12'h000, st}, "done states");
        chk({8'h00, done_opcode}, {8'h00, op}, "done opcode");
        pc_v = pc_v + 16'h0002;
    endtask

    task automatic t_reset();
        chk({14'h0000, mem_req, done}, 16'h0000, "request done in reset");
        chk({arch.acc, arch.flags}, {8'h00, aid_pkg::FLAGS_RST}, "acc flags reset");
        chk(arch.hl, 16'h0000, "hl reset");
    endtask

    task automatic t_xor_imm(input logic [7:0] v);
        acc_m = acc_m ^ v;
        run_op(aid_pkg::OPC_XRI, v, aid_pkg::ST_IMM);
        chk({8'h00, arch.acc}, {8'h00, acc_m}, "xor immediate");
    endtask

    task automatic t_pair_add(input logic [15:0] s);
        sp = s;
        hl_m = hl_m + s;
        run_op(aid_pkg::OPC_DAD_SP, 8'h00, aid_pkg::ST_PAIR);
        chk(arch.hl, hl_m, "pair add");
    endtask

    task automatic t_xor_regs();
        logic [3:0] st;
        for (int i = 0; i < 8; i++) begin
            st = (i == 6) ? aid_pkg::ST_MEM : aid_pkg::ST_REG;
            acc_m = acc_m ^ src_of(i[2:0]);
            run_op({aid_pkg::OPC_XRA_HI, i[2:0]}, 8'h00, st);
            chk({8'h00, arch.acc}, {8'h00, acc_m}, "xor register");
        end
    endtask

    task automatic t_compare();
        logic [2:0] sels [4];
        logic [7:0] src;
        logic [3:0] st;
        sels = '{3'h0, 3'h7, 3'h6, 3'h2};
        for (int i = 0; i < 4; i++) begin
            src = src_of(sels[i]);
            st = (sels[i] == aid_pkg::SEL_MEM) ? aid_pkg::ST_MEM : aid_pkg::ST_REG;
            run_op({aid_pkg::OPC_CMP_HI, sels[i]}, 8'h00, st);
            chk({8'h00, arch.acc}, {8'h00, acc_m}, "compare kept acc");
            chk({8'h00, arch.flags & 8'hD5},
                {8'h00, cmp_flags(acc_m, src)}, "cmp flags");
            cy_m = acc_m < src;
        end
    endtask

    // carry enters from the compare before, so both directions cross it
    task automatic t_rotate();
        logic left;
        for (int i = 0; i < 5; i++) begin
            left = (i < 2);
            if (left) begin
                {cy_m, acc_m} = {acc_m, cy_m};
            end else begin
                {acc_m, cy_m} = {cy_m, acc_m};
            end
            if (left) begin
                run_op(aid_pkg::OPC_RAL, 8'h00, aid_pkg::ST_ROT);
            end else begin
                run_op(aid_pkg::OPC_RAR, 8'h00, aid_pkg::ST_ROT);
            end
            chk({7'h00, arch.flags[aid_pkg::FLAG_CY], arch.acc},
                {7'h00, cy_m, acc_m}, "rotate through carry");
        end
    endtask

    task automatic t_none();
        aid_pkg::aid_arch_t keep;
        keep = arch;
        run_op(8'h00, 8'h00, aid_pkg::ST_NONE);
        chk(arch.hl, keep.hl, "no effect hl");
        chk({arch.acc, arch.flags}, {keep.acc, keep.flags}, "no effect acc flags");
    endtask

    task automatic t_slow();
        lag = 4'h3;
        t_xor_imm(8'h0F);
        acc_m = acc_m ^ src_of(aid_pkg::SEL_MEM);
        run_op({aid_pkg::OPC_XRA_HI, aid_pkg::SEL_MEM}, 8'h00, aid_pkg::ST_MEM);
        chk({8'h00, arch.acc}, {8'h00, acc_m}, "slow xor memory");
        lag = 4'h0;
    endtask

    initial begin
        rst = 1'b1;
        reg_b = 8'h3C;
        reg_c = 8'hA5;
        reg_d = 8'hFF;
        reg_e = 8'h00;
        sp = 16'h0000;
        pc = 16'h0100;
        lag = 4'h0;
        pc_v = 16'h0100;
        acc_m = 8'h00;
        cy_m = 1'b0;
        hl_m = 16'h0000;
        n_errors = 0;
        n_checks = 0;
        repeat (3) @(negedge core_clk);
        t_reset();
        aid_prog_mem_inst.store[16'h0234] = 8'h96;
        rst = 1'b0;
        t_xor_imm(8'h5A);
        t_pair_add(16'h1234);
        t_pair_add(16'hF000);
        t_xor_regs();
        t_xor_imm(8'h80);
        t_compare();
        t_rotate();
        t_none();
        t_slow();
        wrap_up();
    end
endmodule

// [tb/aid_prog_mem.sv]
`timescale 1ns/100ps
// program memory model: answers each fetch after lag wait cycles
module aid_prog_mem (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // fetch port
    input wire logic mem_req,
    input wire logic [15:0] mem_addr,
    output logic mem_ack,
    output logic [7:0] mem_data,
    // wait cycles before each answer
    input wire logic [3:0] lag
);
    logic [7:0] store [0:65535];
    logic [3:0] wait_cnt;
    logic [7:0] last;
    // byte served at the address asked
    assign mem_ack = mem_req && (wait_cnt >= lag);
    // released bus shows the inverse so a stale byte never looks valid
    assign mem_data = mem_ack ? store[mem_addr] : ~last;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wait_cnt <= 4'h0;
            last <= 8'h00;
        end else if (mem_ack) begin
            wait_cnt <= 4'h0;
            last <= store[mem_addr];
        end else if (mem_req) begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule
